// [hw/hise_edge.sv]
// Edge detector for a synchronised vector of event sources
`timescale 1ns/1ps
module hise_edge #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Level in, change pulse out
	input wire logic [W-1:0] level_in,
	output logic [W-1:0] rise,
	output logic [W-1:0] change
);
	logic [W-1:0] prev_r;

	// Holds previous level; reset value equals idle so no false edge
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			prev_r <= '0;
		end else begin
			prev_r <= level_in;
		end
	end

	assign rise = level_in & ~prev_r;
	assign change = level_in ^ prev_r;
endmodule

// [hw/hise_top.sv]
// Interrupt status and enable registers of the host controller
`timescale 1ns/1ps
// Function
// - Any tracked event sets its flag whether or not it is enabled.
// - The interrupt request is high while a flag, its enable and the master gate are all set.
// - Writing 1 clears a flag, writing 0 leaves it, and software can never set one.
// - The root hub change flag at bit 6 sets when any root port status bit changes.
// - The rollover flag at bit 5 sets on each toggle of frame number bit 15.
// - The fatal system error flag at bit 4 always reads zero.
// - The resume flag at bit 3 sets when device resume signalling starts, not on software resume.
// - Each frame start sets the frame start flag at bit 2 and emits a start-of-frame token.
// - The overrun flag at bit 0 sets on a schedule overrun.
// - Each overrun increments the two-bit overrun tally, wrapping.
// - Writing the enable register sets bits written 1 and leaves the rest.
// - Reading the enable register returns its stored value.
// - The master gate at bit 31 gates all interrupts; writing 1 sets it, 0 does nothing.
// - Writing 1 to the enable clear register clears the enable bit, 0 leaves it.
module hise_top #(
	parameter int unsigned PORT_STATUS_W = 64
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [hise_pkg::HISE_AW-1:0] reg_addr,
	input wire logic [hise_pkg::HISE_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [hise_pkg::HISE_DW-1:0] reg_rdata,
	// Event sources, asynchronous levels from the controller core
	input wire logic [PORT_STATUS_W-1:0] root_port_status,
	input wire logic frame_number_msb,
	input wire logic device_resume,
	input wire logic resume_state_entry,
	input wire logic frame_boundary,
	input wire logic schedule_overrun,
	// Outputs
	output logic sof_token,
	output logic [1:0] overrun_tally,
	output logic host_irq
);
	import hise_pkg::*;

	localparam int unsigned NS = PORT_STATUS_W + 5;

	logic [NS-1:0] raw_in;
	logic [NS-1:0] sync1_r;
	logic [NS-1:0] sync2_r;
	logic [NS-1:0] rise;
	logic [NS-1:0] change;
	logic [31:0] flags_r;
	logic [31:0] flags_nxt;
	logic [31:0] enables_r;
	logic [31:0] enables_nxt;
	logic [1:0] tally_r;
	logic [1:0] tally_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic sof_r;
	logic [31:0] events;
	logic [31:0] clr_flags;
	logic [31:0] set_en;
	logic [31:0] clr_en;
	logic wr_flags;
	logic wr_en;
	logic wr_en_clr;
	logic ev_root;
	logic ev_roll;
	logic ev_resume;
	logic ev_frame;
	logic ev_overrun;
	logic resume_sw_r;

	// Bit layout of the synchroniser vector
	assign raw_in = {root_port_status, frame_number_msb, device_resume, frame_boundary,
		schedule_overrun, resume_state_entry};

	// Two-stage synchroniser, first stage read only by the second
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
		end
	end

	hise_edge #(
		.W(NS)
	) u_edge (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.level_in(sync2_r),
		.rise(rise),
		.change(change)
	);

	// Software resume entry is a level; suppress resume detect while it stands
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			resume_sw_r <= 1'b0;
		end else begin
			resume_sw_r <= sync2_r[0];
		end
	end

	// Event decode
	// any port change
	assign ev_root = |change[NS-1:5];
	assign ev_roll = change[4];
	assign ev_resume = rise[3] & ~sync2_r[0] & ~resume_sw_r;
	assign ev_frame = rise[2];
	assign ev_overrun = rise[1];

	always_comb begin
		events = '0;
		events[HISE_B_ROOT_HUB] = ev_root;
		events[HISE_B_ROLLOVER] = ev_roll;
		events[HISE_B_RESUME] = ev_resume;
		events[HISE_B_FRAME_START] = ev_frame;
		events[HISE_B_OVERRUN] = ev_overrun;
	end

	// Write decode; reg_addr is matched against the byte addresses, not the register indices
	// flags access
	assign wr_flags = reg_wr && (reg_addr == HISE_ADDR_FLAGS);
	assign wr_en = reg_wr && (reg_addr == HISE_ADDR_ENABLES);
	assign wr_en_clr = reg_wr && (reg_addr == HISE_ADDR_EN_CLEAR);
	assign clr_flags = wr_flags ? (reg_wdata & HISE_FLAG_MASK) : '0;
	assign set_en = wr_en ? (reg_wdata & HISE_ENABLE_MASK) : '0;
	assign clr_en = wr_en_clr ? (reg_wdata & HISE_ENABLE_MASK) : '0;

	assign flags_nxt = ((flags_r & ~clr_flags) | events) & HISE_FLAG_MASK;
	assign enables_nxt = ((enables_r | set_en) & ~clr_en) & HISE_ENABLE_MASK;
	assign tally_nxt = ev_overrun ? 2'(tally_r + 2'h1) : tally_r;

	// Read mux; unmapped addresses answer zero
	// enables read back
	always_comb begin
		rdata_nxt = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				HISE_ADDR_FLAGS: rdata_nxt = flags_r;
				HISE_ADDR_ENABLES: rdata_nxt = enables_r;
				HISE_ADDR_EN_CLEAR: rdata_nxt = enables_r;
				HISE_ADDR_TALLY: rdata_nxt = {14'h0000, tally_r, 16'h0000};
				default: rdata_nxt = '0;
			endcase
		end
	end

	// Register state
	// reset to zero
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			flags_r <= HISE_RESET_VAL;
			enables_r <= HISE_RESET_VAL;
			tally_r <= HISE_TALLY_RESET;
			rdata_r <= '0;
			sof_r <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			enables_r <= enables_nxt;
			tally_r <= tally_nxt;
			rdata_r <= rdata_nxt;
			sof_r <= ev_frame;
		end
	end

	assign reg_rdata = rdata_r;
	assign overrun_tally = tally_r;
	assign sof_token = sof_r;
	assign host_irq = enables_r[HISE_B_MASTER] & |(flags_r & enables_r & HISE_FLAG_MASK);

	// Checks
	sequence s_overrun_seen;
		ev_overrun;
	endsequence

	property p_flag_sets;
		@(posedge ref_clk) disable iff (!reset_n)
		ev_frame |=> flags_r[HISE_B_FRAME_START];
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("frame flag not set");

	property p_irq;
		@(posedge ref_clk) disable iff (!reset_n)
		host_irq == (enables_r[31] && ((flags_r & enables_r & 32'h0000_007F) != 0));
	endproperty
	a_irq: assert property (p_irq) else $error("irq gate wrong");

	property p_w1c;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_flags && reg_wdata[HISE_B_RESUME] && !ev_resume) |=> !flags_r[HISE_B_RESUME];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared");

	property p_no_sw_set;
		@(posedge ref_clk) disable iff (!reset_n)
		(!flags_r[HISE_B_ROOT_HUB] && !ev_root) |=> !flags_r[HISE_B_ROOT_HUB];
	endproperty
	a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without event");

	property p_roll;
		@(posedge ref_clk) disable iff (!reset_n)
		$changed(sync2_r[4]) |=> flags_r[HISE_B_ROLLOVER];
	endproperty
	a_roll: assert property (p_roll) else $error("rollover missed");

	property p_fatal;
		@(posedge ref_clk) disable iff (!reset_n)
		!flags_r[HISE_B_FATAL];
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal bit set");

	property p_tally;
		@(posedge ref_clk) disable iff (!reset_n)
		s_overrun_seen |=> (tally_r == $past(tally_r) + 2'h1) && flags_r[HISE_B_OVERRUN];
	endproperty
	a_tally: assert property (p_tally) else $error("tally not incremented");

	property p_en_set;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_en && reg_wdata[HISE_B_MASTER]) |=> enables_r[HISE_B_MASTER];
	endproperty
	a_en_set: assert property (p_en_set) else $error("enable not set");

	property p_en_keep;
		@(posedge ref_clk) disable iff (!reset_n)
		(enables_r[HISE_B_MASTER] && !wr_en_clr) |=> enables_r[HISE_B_MASTER];
	endproperty
	a_en_keep: assert property (p_en_keep) else $error("master gate lost");

	property p_en_clear;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_en_clr && reg_wdata[HISE_B_ROOT_HUB]) |=> !enables_r[HISE_B_ROOT_HUB];
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("enable not cleared");

	property p_read;
		@(posedge ref_clk) disable iff (!reset_n)
		(reg_rd && reg_addr == HISE_ADDR_ENABLES && !wr_en && !wr_en_clr)
			|=> reg_rdata == $past(enables_r);
	endproperty
	a_read: assert property (p_read) else $error("enable readback wrong");

	// Frame input seen low then high after the synchroniser
	sequence s_frame_rise;
		!sync2_r[2] ##1 sync2_r[2];
	endsequence

	property p_frame_path;
		@(posedge ref_clk) disable iff (!reset_n)
		s_frame_rise |=> sof_token && flags_r[HISE_B_FRAME_START];
	endproperty
	a_frame_path: assert property (p_frame_path) else $error("frame edge lost");

	property p_sof_pulse;
		@(posedge ref_clk) disable iff (!reset_n)
		ev_frame |=> sof_token;
	endproperty
	a_sof_pulse: assert property (p_sof_pulse) else $error("start token missing");

	property p_sof_only;
		@(posedge ref_clk) disable iff (!reset_n)
		!ev_frame |=> !sof_token;
	endproperty
	a_sof_only: assert property (p_sof_only) else $error("stray start token");

	property p_root_set;
		@(posedge ref_clk) disable iff (!reset_n)
		ev_root |=> flags_r[HISE_B_ROOT_HUB];
	endproperty
	a_root_set: assert property (p_root_set) else $error("root hub flag missed");

	property p_resume_set;
		@(posedge ref_clk) disable iff (!reset_n)
		ev_resume |=> flags_r[HISE_B_RESUME];
	endproperty
	a_resume_set: assert property (p_resume_set) else $error("resume flag missed");

	property p_resume_sw;
		@(posedge ref_clk) disable iff (!reset_n)
		(sync2_r[0] && !flags_r[HISE_B_RESUME]) |=> !flags_r[HISE_B_RESUME];
	endproperty
	a_resume_sw: assert property (p_resume_sw) else $error("resume flag on sw resume");

	property p_tally_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		!ev_overrun |=> $stable(tally_r);
	endproperty
	a_tally_hold: assert property (p_tally_hold) else $error("tally moved");

	property p_reserved;
		@(posedge ref_clk) disable iff (!reset_n)
		((flags_r & ~HISE_FLAG_MASK) == '0) && ((enables_r & ~HISE_ENABLE_MASK) == '0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_rd_unmapped;
		@(posedge ref_clk) disable iff (!reset_n)
		(reg_rd && (reg_addr > HISE_ADDR_TALLY)) |=> (reg_rdata == '0);
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");

	property p_flag_rsv_rd;
		@(posedge ref_clk) disable iff (!reset_n)
		(reg_rd && (reg_addr == HISE_ADDR_FLAGS)) |=> ((reg_rdata & ~HISE_FLAG_MASK) == '0);
	endproperty
	a_flag_rsv_rd: assert property (p_flag_rsv_rd) else $error("flag read reserved bit");

	property p_irq_master;
		@(posedge ref_clk) disable iff (!reset_n)
		!enables_r[HISE_B_MASTER] |-> !host_irq;
	endproperty
	a_irq_master: assert property (p_irq_master) else $error("irq without master gate");

	property p_irq_on;
		@(posedge ref_clk) disable iff (!reset_n)
		(enables_r[HISE_B_MASTER] && flags_r[HISE_B_FRAME_START]
			&& enables_r[HISE_B_FRAME_START]) |-> host_irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missing");

	property p_en_no_clr;
		@(posedge ref_clk) disable iff (!reset_n)
		wr_en |=> ((enables_r & $past(enables_r)) == $past(enables_r));
	endproperty
	a_en_no_clr: assert property (p_en_no_clr) else $error("enable write cleared");

	property p_flag_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_flags && !reg_wdata[HISE_B_FRAME_START] && flags_r[HISE_B_FRAME_START])
			|=> flags_r[HISE_B_FRAME_START];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by zero");

	property p_clr_no_set;
		@(posedge ref_clk) disable iff (!reset_n)
		wr_en_clr |=> ((enables_r | $past(enables_r)) == $past(enables_r));
	endproperty
	a_clr_no_set: assert property (p_clr_no_set) else $error("enable clear set a bit");
endmodule

// [pkg/hise_pkg.sv]
// Package: register map, field positions and reset values of the host interrupt block
package hise_pkg;
	localparam int unsigned HISE_AW = 8;
	localparam int unsigned HISE_DW = 32;
	// Register indices, byte address is four times the index
	localparam logic [7:0] HISE_IDX_FLAGS = 8'h03;
	localparam logic [7:0] HISE_IDX_ENABLES = 8'h04;
	localparam logic [7:0] HISE_IDX_EN_CLEAR = 8'h05;
	localparam logic [7:0] HISE_IDX_TALLY = 8'h06;
	localparam logic [7:0] HISE_ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] HISE_ADDR_ENABLES = 8'h10;
	localparam logic [7:0] HISE_ADDR_EN_CLEAR = 8'h14;
	localparam logic [7:0] HISE_ADDR_TALLY = 8'h18;
	// Bit positions
	localparam int unsigned HISE_B_OVERRUN = 0;
	localparam int unsigned HISE_B_FRAME_START = 2;
	localparam int unsigned HISE_B_RESUME = 3;
	localparam int unsigned HISE_B_FATAL = 4;
	localparam int unsigned HISE_B_ROLLOVER = 5;
	localparam int unsigned HISE_B_ROOT_HUB = 6;
	localparam int unsigned HISE_B_MASTER = 31;
	localparam int unsigned HISE_B_FRAME_MSB = 15;
	localparam int unsigned HISE_TALLY_LSB = 16;
	// Writable masks; fatal error bit is absent from the flag mask
	localparam logic [31:0] HISE_FLAG_MASK = 32'h0000_006D;
	localparam logic [31:0] HISE_ENABLE_MASK = 32'h8000_007D;
	localparam logic [31:0] HISE_RESET_VAL = 32'h0000_0000;
	localparam logic [1:0] HISE_TALLY_RESET = 2'h0;
endpackage

// [verif/hise_host_model.sv]
// Host driver model: register port master for the interrupt block
`timescale 1ns/1ps
module hise_host_model (
	// Clock
	input wire logic ref_clk,
	// Register port
	output logic [hise_pkg::HISE_AW-1:0] reg_addr,
	output logic [hise_pkg::HISE_DW-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [hise_pkg::HISE_DW-1:0] reg_rdata
);
	import hise_pkg::*;
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Callers pass byte addresses, mapped or unmapped
	// One-cycle write; data inverted after so stale values never match
	// Returns one edge later, so the written state is already visible
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		@(posedge ref_clk);
	endtask
	// One-cycle read, data taken at the edge closing the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
endmodule

// [verif/tb_host_irq_status_enable.sv]
// Self-checking bench for the interrupt status and enable block
`timescale 1ns/1ps
module tb_host_irq_status_enable;
	import hise_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [63:0] root_port_status = 64'h0;
	logic [4:0] src = 5'h00;
	logic sof_token;
	logic [1:0] overrun_tally;
	logic host_irq;
	logic [31:0] e;
	int n_fail = 0;
	int check_count = 0;
	int sof_n = 0;
	// Sources: 0 frame msb, 1 device resume, 2 sw resume, 3 frame, 4 overrun
	hise_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.root_port_status(root_port_status), .frame_number_msb(src[0]),
		.device_resume(src[1]), .resume_state_entry(src[2]), .frame_boundary(src[3]),
		.schedule_overrun(src[4]), .sof_token(sof_token), .overrun_tally(overrun_tally),
		.host_irq(host_irq));
	hise_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;
	// Count one-cycle token pulses
	always @(posedge ref_clk) begin
		if (sof_token === 1'b1) sof_n <= sof_n + 1;
	end
	task automatic conclude();
		if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		host.rd(a, d);
		chk(d, exp);
	endtask
	// Fixed wait covers two sync stages and the flag register
	task automatic set_src(input logic [4:0] v);
		@(posedge ref_clk);
		src <= v;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		rd_chk(HISE_ADDR_FLAGS, 32'h0000_0000);
		rd_chk(HISE_ADDR_ENABLES, 32'h0000_0000);
		chk({31'h0, host_irq}, 32'h0000_0000);
	endtask
	task automatic t_enables();
		host.wr(HISE_ADDR_ENABLES, 32'h0000_0041);
		host.wr(HISE_ADDR_ENABLES, 32'h0000_0004);
		rd_chk(HISE_ADDR_ENABLES, 32'h0000_0045);
		host.wr(HISE_ADDR_ENABLES, 32'hFFFF_FFFF);
		rd_chk(HISE_ADDR_ENABLES, 32'h8000_007D);
		host.wr(HISE_ADDR_EN_CLEAR, 32'h0000_0041);
		rd_chk(HISE_ADDR_ENABLES, 32'h8000_003C);
		rd_chk(HISE_ADDR_EN_CLEAR, 32'h8000_003C);
		host.wr(HISE_ADDR_EN_CLEAR, 32'hFFFF_FFFF);
		rd_chk(HISE_ADDR_ENABLES, 32'h0000_0000);
		host.wr(8'hF0, 32'hFFFF_FFFF);
		rd_chk(8'hF0, 32'h0000_0000);
	endtask
	// All events with enables off; flags accumulate in e
	task automatic t_events();
		int n0;
		n0 = sof_n;
		set_src(5'h08);
		set_src(5'h00);
		chk(sof_n - n0, 1);
		e = 32'h0000_0004;
		rd_chk(HISE_ADDR_FLAGS, e);
		set_src(5'h10);
		set_src(5'h00);
		e = e | 32'h0000_0001;
		rd_chk(HISE_ADDR_FLAGS, e);
		chk({30'h0, overrun_tally}, 32'h0000_0001);
		repeat (3) begin
			set_src(5'h10);
			set_src(5'h00);
		end
		chk({30'h0, overrun_tally}, 32'h0000_0000);
		set_src(5'h01);
		e = e | 32'h0000_0020;
		rd_chk(HISE_ADDR_FLAGS, e);
		host.wr(HISE_ADDR_FLAGS, 32'h0000_0020);
		set_src(5'h00);
		rd_chk(HISE_ADDR_FLAGS, e);
		@(posedge ref_clk);
		root_port_status <= 64'h8000_0000_0000_0000;
		repeat (6) @(posedge ref_clk);
		e = e | 32'h0000_0040;
		rd_chk(HISE_ADDR_FLAGS, e);
		set_src(5'h04);
		set_src(5'h06);
		set_src(5'h00);
		rd_chk(HISE_ADDR_FLAGS, e);
		set_src(5'h02);
		set_src(5'h00);
		e = e | 32'h0000_0008;
		rd_chk(HISE_ADDR_FLAGS, e);
		host.wr(HISE_ADDR_FLAGS, 32'hFFFF_FF92);
		rd_chk(HISE_ADDR_FLAGS, e);
		host.wr(HISE_ADDR_FLAGS, 32'hFFFF_FFFF);
		rd_chk(HISE_ADDR_FLAGS, 32'h0000_0000);
	endtask
	// Interrupt gating by enable, master gate and flag clear
	task automatic t_irq();
		set_src(5'h08);
		set_src(5'h00);
		host.wr(HISE_ADDR_ENABLES, 32'h0000_0004);
		chk({31'h0, host_irq}, 32'h0000_0000);
		host.wr(HISE_ADDR_ENABLES, 32'h8000_0000);
		chk({31'h0, host_irq}, 32'h0000_0001);
		host.wr(HISE_ADDR_ENABLES, 32'h0000_0000);
		chk({31'h0, host_irq}, 32'h0000_0001);
		host.wr(HISE_ADDR_EN_CLEAR, 32'h0000_0004);
		chk({31'h0, host_irq}, 32'h0000_0000);
		host.wr(HISE_ADDR_ENABLES, 32'h0000_0004);
		chk({31'h0, host_irq}, 32'h0000_0001);
		host.wr(HISE_ADDR_FLAGS, 32'h0000_0004);
		chk({31'h0, host_irq}, 32'h0000_0000);
		reset_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd_chk(HISE_ADDR_ENABLES, 32'h0000_0000);
		chk({31'h0, host_irq}, 32'h0000_0000);
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_enables();
		t_events();
		t_irq();
		conclude();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		conclude();
	end
endmodule
